// file: inc/ssom_pkg.sv
// Constants shared by the servo status output mapper files
`default_nettype none

package ssom_pkg;

    // ----------------------------------------
    // Widths and counts
    // ----------------------------------------
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int FN_COUNT = 10;
    localparam int PIN_COUNT = 3;
    localparam int SEL_W = 4;
    localparam int WARN_W = 5;
    localparam int TQ_COUNT = 3;

    // ----------------------------------------
    // Status function codes and bit positions
    // ----------------------------------------
    localparam int FN_READY = 0;
    localparam int FN_SERVO_ON = 1;
    localparam int FN_ZERO_SPEED = 2;
    localparam int FN_TARGET_SPEED = 3;
    localparam int FN_POSITION = 4;
    localparam int FN_TORQUE_LIMIT = 5;
    localparam int FN_ALARM = 6;
    localparam int FN_WARNING = 7;
    localparam int FN_BRAKE = 8;
    localparam int FN_OVERLOAD = 9;

    // ----------------------------------------
    // Register word offsets
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] OFS_PIN_SELECT = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_INVERT = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_ZERO_RANGE = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_TARGET_SPEED = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_IN_POSITION = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_TORQUE_LIM0 = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_OVERLOAD = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h9;
    localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 4'hA;
    localparam logic [ADDR_W-1:0] OFS_INT_MASK = 4'hB;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    // Pin one ready, pin two zero speed, pin three alarm
    localparam logic [PIN_COUNT*SEL_W-1:0] RST_PIN_SELECT = 12'h620;
    localparam logic [FN_COUNT-1:0] RST_INVERT = 10'h000;
    localparam logic [DATA_W-1:0] RST_ZERO_RANGE = 16'h000A;
    localparam logic [DATA_W-1:0] RST_TARGET_SPEED = 16'h0100;
    localparam logic [DATA_W-1:0] RST_IN_POSITION = 16'h0010;
    localparam logic [DATA_W-1:0] RST_TORQUE_LIM = 16'h0100;
    localparam logic [DATA_W-1:0] RST_OVERLOAD = 16'h0100;
    localparam logic [FN_COUNT-1:0] RST_INT_MASK = 10'h000;

endpackage

`default_nettype wire

// file: inc/ssom_map_if.sv
// Function levels and pin routing passed to the pin multiplexer
`timescale 1ns/1ps
`default_nettype none

interface ssom_map_if;
    import ssom_pkg::*;
    logic [FN_COUNT-1:0] funcLevel;
    logic [FN_COUNT-1:0] invert;
    logic [PIN_COUNT*SEL_W-1:0] pinSelect;
    logic [PIN_COUNT-1:0] pins;
    modport source (output funcLevel, output invert, output pinSelect, input pins);
    modport mux (input funcLevel, input invert, input pinSelect, output pins);
endinterface

`default_nettype wire

// file: hdl/ssom_pin_mux.sv
// Routes any status function onto any fixed output pin
`timescale 1ns/1ps
`default_nettype none

module ssom_pin_mux
    import ssom_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic ce, // Clock enable
    ssom_map_if.mux map // Levels and routing
);

    logic [PIN_COUNT-1:0] pins_reg;
    logic [PIN_COUNT-1:0] pins_next;
    logic [FN_COUNT-1:0] shown;

    // ----------------------------------------
    // Selection
    // ----------------------------------------
    always_comb begin
        // Polarity per function applied before routing
        shown = map.funcLevel ^ map.invert;
        for (int p = 0; p < PIN_COUNT; p++) begin
            // Codes beyond the function list leave the pin off
            if (map.pinSelect[p*SEL_W +: SEL_W] < SEL_W'(FN_COUNT)) begin
                pins_next[p] = shown[map.pinSelect[p*SEL_W +: SEL_W]];
            end else begin
                pins_next[p] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pins_reg <= '0;
        end else if (ce) begin
            pins_reg <= pins_next;
        end
    end

    assign map.pins = pins_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    pin_route_a: assert property (@(posedge clk) disable iff (rst)
        ce && map.pinSelect[SEL_W-1:0] == SEL_W'(FN_ALARM)
        |=> map.pins[0] == $past(map.funcLevel[FN_ALARM] ^ map.invert[FN_ALARM]))
        else $error("pin one does not follow routed alarm level");

    pin_hold_a: assert property (@(posedge clk) disable iff (rst)
        !ce |=> $stable(map.pins))
        else $error("pins changed while clock enable low");

endmodule // ssom_pin_mux

`default_nettype wire

// file: hdl/ssom_status_mapper.sv
// Servo drive status output mapper with register port and interrupt
// ----------------------------------------
// How it works
// - Any status function routable to any pin
// - Ready only when ready and fault free
// - Servo-on follows control power regardless faults
// - Zero speed while speed within range
// - Target speed while speed reaches target
// - Position reached only in position mode
// - Torque limit when any limit reached
// - Alarm whenever a fault is detected
// - Warning shown before alarm for warning faults
// - Warning on limits, stop, comms, undervoltage
// - Brake output actuates the motor brake
// - Overload warning at configured overload level
// - Routed pin polarity set by user configuration
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none

module ssom_status_mapper
    import ssom_pkg::*;
#(
    parameter int SPEED_W = 16
)(
    input wire logic clk, // System clock, 40 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic ce, // Clock enable, freezes all state
    input wire logic [ADDR_W-1:0] regAddr, // Register word index
    input wire logic [DATA_W-1:0] regWdata, // Write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    output logic [DATA_W-1:0] regRdata, // Read data, cycle after strobe
    input wire logic controlPowerOn, // Control power present
    input wire logic readyToRun, // Drive ready to run
    input wire logic positionMode, // Position control mode active
    input wire logic brakeRequest, // Brake actuation request
    input wire logic faultDetect, // Fault outside the warning class
    input wire logic [WARN_W-1:0] warnCause, // Rev, fwd, estop, comms, undervolt
    input wire logic [SPEED_W-1:0] motorSpeed, // Speed magnitude
    input wire logic [SPEED_W-1:0] positionError, // Signed position error
    input wire logic [SPEED_W-1:0] motorTorque, // Torque magnitude
    input wire logic [SPEED_W-1:0] loadLevel, // Output load level
    output logic driveReadyOut, // Ready level
    output logic servoPowerOnOut, // Servo-on level
    output logic zeroSpeedOut, // Zero speed level
    output logic targetSpeedReachedOut, // Target speed level
    output logic positionReachedOut, // In position level
    output logic torqueLimitReachedOut, // Torque limit level
    output logic faultAlarmOut, // Alarm level
    output logic warningOut, // Warning level
    output logic brakeActuateOut, // Brake level
    output logic overloadWarningOut, // Overload level
    output logic statusPinOne, // Routed pin one
    output logic statusPinTwo, // Routed pin two
    output logic statusPinThree, // Routed pin three
    output logic irq // Level interrupt
);

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    logic [PIN_COUNT*SEL_W-1:0] pinSelect_reg;
    logic [FN_COUNT-1:0] invert_reg;
    logic [DATA_W-1:0] zeroRange_reg;
    logic [DATA_W-1:0] targetSpeed_reg;
    logic [DATA_W-1:0] inPosition_reg;
    logic [DATA_W-1:0] torqueLim_reg [TQ_COUNT];
    logic [DATA_W-1:0] overload_reg;
    logic [FN_COUNT-1:0] intMask_reg;
    logic [FN_COUNT-1:0] intStatus_reg;
    logic [FN_COUNT-1:0] statusLevel_reg;
    logic [FN_COUNT-1:0] statusLevel_next;
    logic [DATA_W-1:0] regRdata_reg;
    logic [DATA_W-1:0] regRdata_next;
    logic [SPEED_W-1:0] posErrMag;
    logic torqueHit;
    logic warnActive;

    function automatic logic wrHit(input logic [ADDR_W-1:0] ofs);
        return regWr && (regAddr == ofs);
    endfunction

    always_ff @(posedge clk) begin
        if (rst) begin
            pinSelect_reg <= RST_PIN_SELECT;
            invert_reg <= RST_INVERT;
        end else if (ce) begin
            if (wrHit(OFS_PIN_SELECT)) begin
                pinSelect_reg <= regWdata[PIN_COUNT*SEL_W-1:0];
            end
            if (wrHit(OFS_INVERT)) begin
                invert_reg <= regWdata[FN_COUNT-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            zeroRange_reg <= RST_ZERO_RANGE;
            targetSpeed_reg <= RST_TARGET_SPEED;
            inPosition_reg <= RST_IN_POSITION;
            overload_reg <= RST_OVERLOAD;
            for (int i = 0; i < TQ_COUNT; i++) begin
                torqueLim_reg[i] <= RST_TORQUE_LIM;
            end
        end else if (ce) begin
            if (wrHit(OFS_ZERO_RANGE)) begin
                zeroRange_reg <= regWdata;
            end
            if (wrHit(OFS_TARGET_SPEED)) begin
                targetSpeed_reg <= regWdata;
            end
            if (wrHit(OFS_IN_POSITION)) begin
                inPosition_reg <= regWdata;
            end
            if (wrHit(OFS_OVERLOAD)) begin
                overload_reg <= regWdata;
            end
            for (int i = 0; i < TQ_COUNT; i++) begin
                if (wrHit(OFS_TORQUE_LIM0 + ADDR_W'(i))) begin
                    torqueLim_reg[i] <= regWdata;
                end
            end
        end
    end

    // ----------------------------------------
    // Status conditions
    // ----------------------------------------
    always_comb begin
        // Two's complement magnitude; most negative value maps to itself, read unsigned as its full magnitude
        posErrMag = positionError[SPEED_W-1] ? SPEED_W'(-positionError) : positionError;
        torqueHit = 1'b0;
        for (int i = 0; i < TQ_COUNT; i++) begin
            if (motorTorque >= SPEED_W'(torqueLim_reg[i])) begin
                torqueHit = 1'b1;
            end
        end
        warnActive = |warnCause;
    end

    always_comb begin
        statusLevel_next = '0;
        // Warning faults also block ready, they are faults too
        statusLevel_next[FN_READY] = readyToRun && !faultDetect && !warnActive;
        statusLevel_next[FN_SERVO_ON] = controlPowerOn;
        statusLevel_next[FN_ZERO_SPEED] = motorSpeed <= SPEED_W'(zeroRange_reg);
        statusLevel_next[FN_TARGET_SPEED] = motorSpeed >= SPEED_W'(targetSpeed_reg);
        statusLevel_next[FN_POSITION] = positionMode
            && (posErrMag <= SPEED_W'(inPosition_reg));
        statusLevel_next[FN_TORQUE_LIMIT] = torqueHit;
        // Warning-class faults raise alarm only once warning is already shown
        statusLevel_next[FN_ALARM] = faultDetect
            || (warnActive && statusLevel_reg[FN_WARNING]);
        statusLevel_next[FN_WARNING] = warnActive;
        statusLevel_next[FN_BRAKE] = brakeRequest;
        statusLevel_next[FN_OVERLOAD] = loadLevel >= SPEED_W'(overload_reg);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            statusLevel_reg <= '0;
        end else if (ce) begin
            statusLevel_reg <= statusLevel_next;
        end
    end

    assign driveReadyOut = statusLevel_reg[FN_READY];
    assign servoPowerOnOut = statusLevel_reg[FN_SERVO_ON];
    assign zeroSpeedOut = statusLevel_reg[FN_ZERO_SPEED];
    assign targetSpeedReachedOut = statusLevel_reg[FN_TARGET_SPEED];
    assign positionReachedOut = statusLevel_reg[FN_POSITION];
    assign torqueLimitReachedOut = statusLevel_reg[FN_TORQUE_LIMIT];
    assign faultAlarmOut = statusLevel_reg[FN_ALARM];
    assign warningOut = statusLevel_reg[FN_WARNING];
    assign brakeActuateOut = statusLevel_reg[FN_BRAKE];
    assign overloadWarningOut = statusLevel_reg[FN_OVERLOAD];

    // ----------------------------------------
    // Pin routing
    // ----------------------------------------
    ssom_map_if mapBus ();

    assign mapBus.funcLevel = statusLevel_reg;
    assign mapBus.invert = invert_reg;
    assign mapBus.pinSelect = pinSelect_reg;

    ssom_pin_mux pinMux (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .map(mapBus.mux)
    );

    assign statusPinOne = mapBus.pins[0];
    assign statusPinTwo = mapBus.pins[1];
    assign statusPinThree = mapBus.pins[2];

    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            intMask_reg <= RST_INT_MASK;
        end else if (ce && wrHit(OFS_INT_MASK)) begin
            intMask_reg <= regWdata[FN_COUNT-1:0];
        end
    end

    // Rising edge of a function is the event; set beats a same-cycle clear
    always_ff @(posedge clk) begin
        if (rst) begin
            intStatus_reg <= '0;
        end else if (ce) begin
            intStatus_reg <= (intStatus_reg
                & ~(wrHit(OFS_INT_STATUS) ? regWdata[FN_COUNT-1:0] : '0))
                | (statusLevel_next & ~statusLevel_reg);
        end
    end

    assign irq = |(intStatus_reg & intMask_reg);

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_comb begin
        regRdata_next = '0;
        unique case (regAddr)
            OFS_PIN_SELECT: regRdata_next = DATA_W'(pinSelect_reg);
            OFS_INVERT: regRdata_next = DATA_W'(invert_reg);
            OFS_ZERO_RANGE: regRdata_next = zeroRange_reg;
            OFS_TARGET_SPEED: regRdata_next = targetSpeed_reg;
            OFS_IN_POSITION: regRdata_next = inPosition_reg;
            OFS_TORQUE_LIM0: regRdata_next = torqueLim_reg[0];
            OFS_TORQUE_LIM0 + 4'h1: regRdata_next = torqueLim_reg[1];
            OFS_TORQUE_LIM0 + 4'h2: regRdata_next = torqueLim_reg[2];
            OFS_OVERLOAD: regRdata_next = overload_reg;
            OFS_STATUS: regRdata_next = DATA_W'(statusLevel_reg);
            OFS_INT_STATUS: regRdata_next = DATA_W'(intStatus_reg);
            OFS_INT_MASK: regRdata_next = DATA_W'(intMask_reg);
            default: regRdata_next = '0;
        endcase
    end

    // Data held outside the answer cycle is zero so stale values never show
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdata_reg <= '0;
        end else if (ce) begin
            regRdata_reg <= regRd ? regRdata_next : '0;
        end
    end

    assign regRdata = regRdata_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    ready_block_a: assert property (@(posedge clk) disable iff (rst)
        ce && (faultDetect || warnCause != '0) |=> !driveReadyOut)
        else $error("ready shown while a fault is present");

    servo_power_a: assert property (@(posedge clk) disable iff (rst)
        ce && controlPowerOn && faultDetect |=> servoPowerOnOut && !driveReadyOut)
        else $error("servo-on not independent of fault");

    zero_speed_a: assert property (@(posedge clk) disable iff (rst)
        ce |=> zeroSpeedOut == ($past(motorSpeed) <= $past(zeroRange_reg)))
        else $error("zero speed level wrong");

    target_speed_a: assert property (@(posedge clk) disable iff (rst)
        ce && motorSpeed < targetSpeed_reg |=> !targetSpeedReachedOut)
        else $error("target speed held below target");

    pos_mode_a: assert property (@(posedge clk) disable iff (rst)
        ce && !positionMode |=> !positionReachedOut)
        else $error("position reached outside position mode");

    torque_limit_a: assert property (@(posedge clk) disable iff (rst)
        ce && motorTorque >= torqueLim_reg[2] |=> torqueLimitReachedOut)
        else $error("torque limit not flagged");

    fault_alarm_a: assert property (@(posedge clk) disable iff (rst)
        ce && faultDetect |=> faultAlarmOut)
        else $error("alarm missing on fault");

    warn_first_a: assert property (@(posedge clk) disable iff (rst)
        ce && !faultDetect && !warningOut |=> !faultAlarmOut)
        else $error("alarm before warning shown");

    warn_level_a: assert property (@(posedge clk) disable iff (rst)
        ce ##0 warnCause != '0 |=> warningOut ##0 ($past(warnCause) != '0))
        else $error("warning missing on warning fault");

    brake_level_a: assert property (@(posedge clk) disable iff (rst)
        ce |=> brakeActuateOut == $past(brakeRequest))
        else $error("brake does not follow request");

    overload_level_a: assert property (@(posedge clk) disable iff (rst)
        ce && loadLevel < overload_reg |=> !overloadWarningOut)
        else $error("overload flagged below level");

    irq_level_a: assert property (@(posedge clk) disable iff (rst)
        ce && faultDetect && !faultAlarmOut |=> irq || !intMask_reg[FN_ALARM])
        else $error("interrupt missing on unmasked alarm rise");

    int_hold_a: assert property (@(posedge clk) disable iff (rst)
        !ce |=> $stable(intStatus_reg))
        else $error("interrupt status changed while clock enable low");

endmodule // ssom_status_mapper

`default_nettype wire

// file: verification/ssom_ctrl_model.sv
// Machine controller model that watches the routed status pins
`timescale 1ns/1ps
`default_nettype none

module ssom_ctrl_model (
    input wire logic clk, // System clock
    input wire logic rst, // Synchronous reset
    input wire logic [2:0] pins, // Status pins three, two, one
    output logic [2:0] seenPins, // Pins as last sampled
    output logic [7:0] pinThreeRises // Rising edges seen on pin three
);
    // ----------------------------------------
    // Sampling
    // ----------------------------------------
    // Edges are counted from the live pin against the registered sample, as a real input card would
    always_ff @(posedge clk) begin
        if (rst) begin
            seenPins <= 3'h0;
            pinThreeRises <= 8'h00;
        end else begin
            seenPins <= pins;
            if (pins[2] && !seenPins[2]) begin
                pinThreeRises <= pinThreeRises + 8'h01;
            end
        end
    end
endmodule // ssom_ctrl_model

`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the servo status output mapper
`timescale 1ns/1ps
`default_nettype none

module tb;
    import ssom_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [ADDR_W-1:0] regAddr = 4'h0;
    logic [DATA_W-1:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [DATA_W-1:0] regRdata;
    logic powerOn = 1'b1, readyRun = 1'b1, posMode = 1'b0, brakeReq = 1'b0, fault = 1'b0;
    logic [WARN_W-1:0] warnCause = 5'h00;
    logic [15:0] speed = 16'h0050, posErr = 16'h0000, torque = 16'h0000, load = 16'h0000;
    logic readyO, servoO, zeroO, targetO, posO, torqueO, alarmO, warnO, brakeO, overO;
    wire logic [2:0] pins;
    logic [2:0] seenPins;
    logic [7:0] alarmRises;
    logic irq;
    logic [DATA_W-1:0] rd;
    logic [9:0] lv;
    int fail_count = 0;
    int check_count = 0;
    logic [DATA_W-1:0] rstVal [0:15] = '{16'h0620, 16'h0000, 16'h000A, 16'h0100, 16'h0010,
        16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] errTab [0:3] = '{16'h0010, 16'hFFF0, 16'h0011, 16'hFFEF};

    always #12.5 clk = ~clk;
    assign lv = {overO, brakeO, warnO, alarmO, torqueO, posO, targetO, zeroO, servoO, readyO};

    ssom_status_mapper u_dut (.clk(clk), .rst(rst), .ce(ce), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .controlPowerOn(powerOn), .readyToRun(readyRun), .positionMode(posMode),
        .brakeRequest(brakeReq), .faultDetect(fault), .warnCause(warnCause),
        .motorSpeed(speed), .positionError(posErr), .motorTorque(torque), .loadLevel(load),
        .driveReadyOut(readyO), .servoPowerOnOut(servoO), .zeroSpeedOut(zeroO),
        .targetSpeedReachedOut(targetO), .positionReachedOut(posO),
        .torqueLimitReachedOut(torqueO), .faultAlarmOut(alarmO), .warningOut(warnO),
        .brakeActuateOut(brakeO), .overloadWarningOut(overO), .statusPinOne(pins[0]),
        .statusPinTwo(pins[1]), .statusPinThree(pins[2]), .irq(irq));

    ssom_ctrl_model u_ctrl (.clk(clk), .rst(rst), .pins(pins), .seenPins(seenPins),
        .pinThreeRises(alarmRises));

    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask

    task automatic check_word(input string name, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic check_bit(input string name, input logic e, input logic g);
        check_word(name, {15'h0000, e}, {15'h0000, g});
    endtask

    task automatic close_out;
        if (fail_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (i != 9 && i != 10) begin
                reg_read(i[3:0], rd);
                check_word("reset value", rstVal[i], rd);
            end
        end
        reg_write(4'hC, 16'hFFFF);
        reg_read(4'hC, rd);
        check_word("unmapped", 16'h0000, rd);
        check_word("levels idle", 16'h0003, {6'h00, lv});
        check_word("default pins", 16'h0001, {13'h0000, pins});
        // Fault: alarm up, ready down, servo-on kept, pin three two cycles late
        @(posedge clk);
        fault <= 1'b1;
        tick(1);
        check_word("fault levels", 16'h0042, {6'h00, lv});
        check_bit("servo on", 1'b1, servoO);
        check_bit("pin three early", 1'b0, pins[2]);
        tick(1);
        check_bit("pin three", 1'b1, pins[2]);
        @(posedge clk);
        fault <= 1'b0;
        tick(3);
        check_word("fault clear", 16'h0003, {6'h00, lv});
        check_word("alarm edges", 16'h0001, {8'h00, alarmRises});
        // Each warning cause: warning one cycle ahead of alarm
        for (int i = 0; i < WARN_W; i++) begin
            @(posedge clk);
            warnCause <= 5'h01 << i;
            tick(1);
            check_word("warn first", 16'h0082, {6'h00, lv});
            tick(1);
            check_word("warn alarm", 16'h00C2, {6'h00, lv});
            @(posedge clk);
            warnCause <= 5'h00;
            tick(3);
            check_word("warn clear", 16'h0003, {6'h00, lv});
        end
        // Threshold boundaries
        @(posedge clk);
        speed <= 16'h000A;
        tick(1);
        check_bit("zero at range", 1'b1, zeroO);
        @(posedge clk);
        speed <= 16'h000B;
        tick(1);
        check_bit("zero above", 1'b0, zeroO);
        @(posedge clk);
        speed <= 16'h0100;
        tick(1);
        check_bit("target reached", 1'b1, targetO);
        @(posedge clk);
        speed <= 16'h00FF;
        tick(1);
        check_bit("target below", 1'b0, targetO);
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 4; i++) begin
                @(posedge clk);
                posMode <= m[0];
                posErr <= errTab[i];
                tick(1);
                check_bit("in position", m[0] && i < 2, posO);
            end
        end
        for (int i = 0; i < 3; i++) begin
            reg_write(4'h5 + i[3:0], 16'h0080);
            for (int j = 0; j < 2; j++) begin
                @(posedge clk);
                torque <= 16'h0080 - j[15:0];
                tick(1);
                check_bit("torque limit", j == 0, torqueO);
            end
            reg_write(4'h5 + i[3:0], 16'h0300);
        end
        @(posedge clk);
        load <= 16'h0100;
        brakeReq <= 1'b1;
        tick(1);
        check_word("brake overload", 16'h0303, {6'h00, lv});
        @(posedge clk);
        load <= 16'h00FF;
        tick(1);
        check_bit("overload below", 1'b0, overO);
        @(posedge clk);
        load <= 16'h0100;
        tick(1);
        // Status register is read-only; levels now 0x303
        reg_write(OFS_STATUS, 16'h0000);
        reg_read(OFS_STATUS, rd);
        check_word("status", 16'h0303, rd);
        // Route every function to pins one and two, pin three off
        for (int f = 0; f < 10; f++) begin
            reg_write(OFS_PIN_SELECT, {4'h0, 4'hF, f[3:0], f[3:0]});
            reg_write(OFS_INVERT, 16'h0000);
            tick(2);
            check_bit("routed pin", lv[f], pins[0]);
            check_bit("pin off", 1'b0, pins[2]);
            reg_write(OFS_INVERT, 16'h03FF);
            tick(2);
            check_bit("inverted pin", !lv[f], pins[1]);
            check_bit("seen inverted", !lv[f], seenPins[0]);
        end
        // Interrupt: unmasked, raised, masked, cleared
        reg_write(OFS_INT_STATUS, 16'h03FF);
        reg_write(OFS_INT_MASK, 16'h0040);
        check_bit("irq idle", 1'b0, irq);
        @(posedge clk);
        fault <= 1'b1;
        tick(2);
        check_bit("irq raised", 1'b1, irq);
        reg_read(OFS_INT_STATUS, rd);
        check_word("int status", 16'h0040, rd & 16'h0040);
        reg_write(OFS_INT_MASK, 16'h0000);
        check_bit("irq masked", 1'b0, irq);
        reg_write(OFS_INT_MASK, 16'h0040);
        reg_write(OFS_INT_STATUS, 16'h0040);
        check_bit("irq cleared", 1'b0, irq);
        // Clock enable low freezes levels while the fault clears
        @(posedge clk);
        ce <= 1'b0;
        fault <= 1'b0;
        tick(2);
        check_bit("frozen alarm", 1'b1, alarmO);
        @(posedge clk);
        ce <= 1'b1;
        tick(1);
        check_bit("thawed alarm", 1'b0, alarmO);
        // Second reset returns outputs low
        @(posedge clk);
        rst <= 1'b1;
        tick(2);
        check_word("reset outputs", 16'h0000, {2'h0, irq, pins, lv});
        close_out();
    end
endmodule // tb

`default_nettype wire
